// ==== wdt_pkg.sv ====
package wdt_pkg;
    // ========================================
    // Register offsets (byte addresses)
    localparam logic [3:0] OFF_LOAD    = 4'h0;
    localparam logic [3:0] OFF_VALUE   = 4'h4;
    localparam logic [3:0] OFF_CONTROL = 4'h8;
    localparam logic [3:0] OFF_CLEAR   = 4'hC;
    localparam logic [3:0] OFF_STATUS  = 4'h0;
    // ========================================
    // Control field positions
    localparam int CTL_UP      = 8;
    localparam int CTL_EN      = 7;
    localparam int CTL_PERIOD  = 6;
    localparam int CTL_WDOG    = 5;
    localparam int CTL_PRE_LO  = 2;
    localparam int CTL_IRQ     = 1;
    localparam int CTL_PDHALT  = 0;
    localparam logic [15:0] CTL_WMASK = 16'h01EF;
    // ========================================
    // Reset values
    localparam logic [15:0] LOAD_RST  = 16'h0050;
    localparam logic [15:0] VALUE_RST = 16'h0050;
    localparam logic [15:0] CTL_RST   = 16'h0000;
    // ========================================
    // Prescaler codes and divide counts
    localparam logic [1:0] PRE_DIV1   = 2'h0;
    localparam logic [1:0] PRE_DIV16  = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam logic [7:0] DIV16_TOP  = 8'h0F;
    localparam logic [7:0] DIV256_TOP = 8'hFF;
endpackage : wdt_pkg

// ==== wdt_presc_if.sv ====
`timescale 1ns/10ps
interface wdt_presc_if;
    logic       src_tick;
    logic [1:0] code;
    logic       run;
    logic       tick;
    modport ctrl (output src_tick, output code, output run, input tick);
    modport div  (input src_tick, input code, input run, output tick);
endinterface : wdt_presc_if

// ==== wdt_presc.sv ====
`timescale 1ns/10ps
module wdt_presc (
    input  wire logic mclk,
    input  wire logic rst,
    wdt_presc_if.div  pif
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } wdt_presc_state_t;
    wdt_presc_state_t st;
    wdt_presc_state_t next_st;
    // ========================================
    // Source clock divider
    always_comb
    begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (pif.run && pif.src_tick)
        begin
            unique case (pif.code)
                wdt_pkg::PRE_DIV1:
                begin
                    next_st.tick = 1'b1;
                    next_st.cnt  = 8'h00;
                end
                wdt_pkg::PRE_DIV16:
                begin
                    next_st.tick = (st.cnt[3:0] == wdt_pkg::DIV16_TOP[3:0]);
                    next_st.cnt  = {4'h0, st.cnt[3:0] + 4'h1};
                end
                wdt_pkg::PRE_DIV256:
                begin
                    next_st.tick = (st.cnt == wdt_pkg::DIV256_TOP);
                    next_st.cnt  = st.cnt + 8'h01;
                end
                default:
                begin
                    next_st.tick = 1'b0;
                end
            endcase
        end
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    assign pif.tick = st.tick;
endmodule : wdt_presc

// ==== wdt_top.sv ====
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
// Summary of operation
// - Outside watchdog mode, direction bit one counts up per tick, zero counts down; watchdog mode counts down
// - Counter advances only while the enable bit is one
// - Mode bit one selects periodic, zero selects free running
// - Watchdog bit set puts the timer in watchdog operation
// - Prescaler divides by 1, 16, 256; code 11 reserved
// - At zero in watchdog mode: interrupt if option set, else reset
// - In peripheral power-down, halt bit one stops the counter
// - Reload on overflow in periodic mode; on clear write in watchdog mode
// - Watchdog locks load and control until power-on reset
// - Counter pauses while the debugger holds the core
module wdt_top #(
    parameter int CNT_W = 16
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        por,
    input  wire logic        lp_osc_tick,
    input  wire logic        debug_halt,
    input  wire logic        periph_powerdown,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             wdt_irq,
    output logic             wdt_reset_req
);
    typedef struct packed {
        logic [15:0]      load;
        logic [CNT_W-1:0] value;
        logic [15:0]      ctl;
        logic             locked;
        logic             irq;
        logic             rst_req;
        logic             fired;
        logic [31:0]      rdata;
        logic             ack;
        logic             err;
    } wdt_state_t;
    wdt_state_t st;
    wdt_state_t next_st;
    wdt_presc_if pif ();
    wdt_presc u_presc (
        .mclk (mclk),
        .rst  (rst),
        .pif  (pif)
    );
    // ========================================
    // Byte-lane merge
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
        merge16 = old;
        if (sel[0])
        begin
            merge16[7:0] = d[7:0];
        end
        if (sel[1])
        begin
            merge16[15:8] = d[15:8];
        end
    endfunction : merge16
    logic req;
    logic wr;
    logic run;
    logic wrap;
    logic wdog;
    assign req  = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
    assign wr   = req && wb_we_i;
    assign wdog = st.ctl[wdt_pkg::CTL_WDOG];
    assign wrap = run && pif.tick && !wdog
                  && (st.ctl[wdt_pkg::CTL_UP] ? &st.value : st.value == '0);
    assign run = st.ctl[wdt_pkg::CTL_EN] && !debug_halt
                 && !(periph_powerdown && st.ctl[wdt_pkg::CTL_PDHALT]);
    assign pif.src_tick = lp_osc_tick;
    assign pif.code     = st.ctl[wdt_pkg::CTL_PRE_LO +: 2];
    assign pif.run      = run;
    // ========================================
    // Next state
    always_comb
    begin
        next_st       = st;
        next_st.ack   = 1'b0;
        next_st.err   = 1'b0;
        next_st.rdata = 32'h0000_0000;
        // ========================================
        // Counter
        if (run && pif.tick)
        begin
            if (wdog)
            begin
                if (st.value != '0)
                begin
                    next_st.value = st.value - 1'b1;
                end
            end
            else if (st.ctl[wdt_pkg::CTL_UP])
            begin
                if (&st.value && st.ctl[wdt_pkg::CTL_PERIOD])
                begin
                    next_st.value = CNT_W'(st.load);
                    next_st.irq   = 1'b1;
                end
                else
                begin
                    next_st.value = st.value + 1'b1;
                    next_st.irq   = st.irq | (&st.value);
                end
            end
            else
            begin
                if (st.value == '0 && st.ctl[wdt_pkg::CTL_PERIOD])
                begin
                    next_st.value = CNT_W'(st.load);
                    next_st.irq   = 1'b1;
                end
                else
                begin
                    next_st.value = st.value - 1'b1;
                    next_st.irq   = st.irq | (st.value == '0);
                end
            end
        end
        if (wdog && st.value == '0 && !st.fired)
        begin
            next_st.fired = 1'b1;
            if (st.ctl[wdt_pkg::CTL_IRQ])
            begin
                next_st.irq = 1'b1;
            end
            else
            begin
                next_st.rst_req = 1'b1;
            end
        end
        // ========================================
        // Bus access
        if (req)
        begin
            next_st.ack = 1'b1;
            if (wr)
            begin
                unique case (wb_adr_i)
                    wdt_pkg::OFF_LOAD:
                    begin
                        if (!st.locked)
                        begin
                            next_st.load = merge16(st.load, wb_dat_i, wb_sel_i);
                        end
                    end
                    wdt_pkg::OFF_CONTROL:
                    begin
                        if (!st.locked)
                        begin
                            next_st.ctl = merge16(st.ctl, wb_dat_i, wb_sel_i)
                                          & wdt_pkg::CTL_WMASK;
                            next_st.locked = next_st.ctl[wdt_pkg::CTL_WDOG];
                        end
                    end
                    wdt_pkg::OFF_CLEAR:
                    begin
                        if (wb_sel_i[0])
                        begin
                            if (wdog)
                            begin
                                next_st.value   = CNT_W'(st.load);
                                next_st.fired   = 1'b0;
                                next_st.irq     = 1'b0;
                                next_st.rst_req = 1'b0;
                            end
                            else
                            begin
                                next_st.irq = wrap;
                            end
                        end
                    end
                    wdt_pkg::OFF_VALUE:
                    begin
                        next_st.ack = 1'b1;
                    end
                    default:
                    begin
                        next_st.ack = 1'b0;
                        next_st.err = 1'b1;
                    end
                endcase
            end
            else
            begin
                unique case (wb_adr_i)
                    wdt_pkg::OFF_LOAD:
                    begin
                        next_st.rdata = {16'h0000, st.load};
                    end
                    wdt_pkg::OFF_VALUE:
                    begin
                        next_st.rdata = 32'(st.value);
                    end
                    wdt_pkg::OFF_CONTROL:
                    begin
                        next_st.rdata = {16'h0000, st.ctl};
                    end
                    wdt_pkg::OFF_CLEAR:
                    begin
                        next_st.rdata = {30'h0000_0000, st.rst_req, st.irq};
                    end
                    default:
                    begin
                        next_st.ack = 1'b0;
                        next_st.err = 1'b1;
                    end
                endcase
            end
        end
    end
    // ========================================
    // State register
    always_ff @(posedge mclk)
    begin
        if (por)
        begin
            st.load    <= wdt_pkg::LOAD_RST;
            st.value   <= CNT_W'(wdt_pkg::VALUE_RST);
            st.ctl     <= wdt_pkg::CTL_RST;
            st.locked  <= 1'b0;
            st.irq     <= 1'b0;
            st.rst_req <= 1'b0;
            st.fired   <= 1'b0;
            st.rdata   <= 32'h0000_0000;
            st.ack     <= 1'b0;
            st.err     <= 1'b0;
        end
        else if (rst)
        begin
            st         <= next_st;
            st.rst_req <= 1'b0;
            st.ack     <= 1'b0;
            st.err     <= 1'b0;
            st.rdata   <= 32'h0000_0000;
            if (!st.locked)
            begin
                st.load  <= wdt_pkg::LOAD_RST;
                st.value <= CNT_W'(wdt_pkg::VALUE_RST);
                st.ctl   <= wdt_pkg::CTL_RST;
                st.irq   <= 1'b0;
                st.fired <= 1'b0;
                st.locked <= 1'b0;
            end
        end
        else
        begin
            st <= next_st;
        end
    end
    assign wb_dat_o      = st.rdata;
    assign wb_ack_o      = st.ack;
    assign wb_err_o      = st.err;
    assign wdt_irq       = st.irq;
    assign wdt_reset_req = st.rst_req;
endmodule : wdt_top

// ==== wdt_top_chk.sv ====
`timescale 1ns/10ps
module wdt_top_chk #(
    parameter int CNT_W = 16
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        por,
    input wire logic        lp_osc_tick,
    input wire logic        debug_halt,
    input wire logic        periph_powerdown,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        wdt_irq,
    input wire logic        wdt_reset_req
);
    // ========================================
    // Bus request taken
    logic taken;
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    default clocking @(posedge mclk); endclocking
    // ========================================
    // Assertions
    chk_bus_answer : assert property (disable iff (rst || por)
        taken |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o))
        else $error("bus answer missing or too long");
    chk_err_unmapped : assert property (disable iff (rst || por)
        taken && wb_adr_i[1:0] != 2'b00 |=> wb_err_o)
        else $error("unmapped access not refused");
    chk_req_hold : assert property (disable iff (rst || por)
        wdt_reset_req && !(taken && wb_we_i && wb_adr_i == wdt_pkg::OFF_CLEAR)
        |=> wdt_reset_req)
        else $error("reset request dropped early");
    chk_req_excl : assert property (disable iff (rst || por)
        $rose(wdt_reset_req) |-> !$rose(wdt_irq))
        else $error("reset and interrupt together");
    chk_rst_clear : assert property (disable iff (por)
        rst |=> !wdt_reset_req)
        else $error("reset request kept over reset");
    chk_por_clear : assert property (
        por |=> !wdt_irq && !wdt_reset_req)
        else $error("power-on reset left outputs set");
    chk_halt_freeze : assert property (disable iff (rst || por)
        debug_halt [*4] |-> !$rose(wdt_irq) && !$rose(wdt_reset_req))
        else $error("event while debug halted");
    chk_tick_needed : assert property (disable iff (rst || por)
        !lp_osc_tick [*4] |-> !$rose(wdt_irq) && !$rose(wdt_reset_req))
        else $error("event without source tick");
    cover property (taken && wb_we_i);
    cover property ($rose(wdt_irq));
    cover property ($rose(wdt_reset_req));
endmodule : wdt_top_chk

bind wdt_top wdt_top_chk #(.CNT_W(CNT_W)) i_chk (
    .mclk(mclk), .rst(rst), .por(por), .lp_osc_tick(lp_osc_tick),
    .debug_halt(debug_halt), .periph_powerdown(periph_powerdown),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req));

// ==== tb.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
    logic        mclk, rst, por, tick, dbg, pd, req, we, ack, berr, irq, rreq, qe;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic [31:0] seed = 32'hbd36_f1ce;
    int          err_total = 0;
    int          checked = 0;
    int          cycles = 0;
    wdt_top #(.CNT_W(16)) i_dut (.mclk(mclk), .rst(rst), .por(por), .lp_osc_tick(tick),
        .debug_halt(dbg), .periph_powerdown(pd), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(berr), .wdt_irq(irq), .wdt_reset_req(rreq));
    // ========================================
    // Clock, timeout, helpers
    initial
    begin
        mclk = 0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic wrap_up();
        if (err_total == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int delta(logic [15:0] c, int t, logic h, logic p);
        int d;
        if (!c[wdt_pkg::CTL_EN] || h || (p && c[wdt_pkg::CTL_PDHALT]))
            return 0;
        d = (c[3:2] == 2'h0) ? t : (c[3:2] == 2'h1) ? t / 16 : (c[3:2] == 2'h2) ? t / 256 : 0;
        return c[wdt_pkg::CTL_UP] ? d : -d;
    endfunction : delta
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        req <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge mclk);
        end
        while (ack !== 1'b1 && berr !== 1'b1);
        q = rdat;
        qe = berr;
        req <= 0;
        we <= 0;
        @(posedge mclk);
    endtask : bus
    task automatic pulses(input int n);
        repeat (n)
        begin
            tick <= 1;
            @(posedge mclk);
            tick <= 0;
            @(posedge mclk);
        end
    endtask : pulses
    task automatic resets(input logic p);
        rst <= 1;
        por <= p;
        repeat (20) @(posedge mclk);
        rst <= 0;
        por <= 0;
        @(posedge mclk);
    endtask : resets
    // ========================================
    // Main sequence
    logic [15:0] cv [9] = '{16'h0180, 16'h0080, 16'h0184, 16'h0188, 16'h018c,
                            16'h0100, 16'h01c0, 16'h0181, 16'h0180};
    logic [1:0]  hp [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h1};
    initial
    begin
        logic [15:0] v;
        logic [31:0] r;
        int          t;
        {rst, por, tick, dbg, pd, req, we, adr, wdat} = {2'b11, 41'h0};
        sel = 4'b0011;
        resets(1);
        bus(0, wdt_pkg::OFF_LOAD, 0);
        `CHK(q[15:0], wdt_pkg::LOAD_RST)
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], wdt_pkg::VALUE_RST)
        bus(0, wdt_pkg::OFF_CONTROL, 0);
        `CHK(q[15:0], wdt_pkg::CTL_RST)
        bus(0, 4'h2, 0);
        `CHK(qe, 1'b1)
        repeat (4)
        begin
            r = rnd();
            bus(1, wdt_pkg::OFF_LOAD, r);
            bus(0, wdt_pkg::OFF_LOAD, 0);
            `CHK(q[15:0], r[15:0])
            bus(1, wdt_pkg::OFF_CONTROL, {16'h0, r[31:16] & 16'h01cf});
            bus(0, wdt_pkg::OFF_CONTROL, 0);
            `CHK(q[15:0], r[31:16] & 16'h01cf)
        end
        bus(0, wdt_pkg::OFF_VALUE, 0);
        v = q[15:0];
        bus(1, wdt_pkg::OFF_VALUE, {16'h0, ~v});
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], v)
        for (int i = 0; i < 9; i++)
        begin
            t = (cv[i][3:2] == 2'h1) ? 32 : (cv[i][3:2] == 2'h2) ? 512 : 1 + int'(rnd() % 12);
            bus(1, wdt_pkg::OFF_CONTROL, {16'h0, cv[i]});
            dbg <= hp[i][1];
            pd <= hp[i][0];
            bus(0, wdt_pkg::OFF_VALUE, 0);
            v = q[15:0];
            pulses(t);
            bus(0, wdt_pkg::OFF_VALUE, 0);
            `CHK(q[15:0], 16'(int'(v) + delta(cv[i], t, hp[i][1], hp[i][0])))
        end
        dbg <= 0;
        pd <= 0;
        r = rnd();
        bus(1, wdt_pkg::OFF_LOAD, {24'h0, r[7:0]});
        bus(1, wdt_pkg::OFF_CONTROL, 16'h00c0);
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        bus(0, wdt_pkg::OFF_VALUE, 0);
        v = q[15:0];
        pulses(int'(v) + 1);
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], {8'h00, r[7:0]})
        `CHK(irq, 1'b1)
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        `CHK(irq, 1'b0)
        bus(1, wdt_pkg::OFF_CONTROL, 16'h0080);
        pulses(int'(r[7:0]) + 1);
        bus(0, wdt_pkg::OFF_CLEAR, 0);
        `CHK(q, 32'h0000_0001)
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], 16'hffff)
        bus(1, wdt_pkg::OFF_LOAD, 5);
        bus(1, wdt_pkg::OFF_CONTROL, 16'h00a2);
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], 16'h0005)
        bus(1, wdt_pkg::OFF_LOAD, 16'h1234);
        bus(0, wdt_pkg::OFF_LOAD, 0);
        `CHK(q[15:0], 16'h0005)
        bus(1, wdt_pkg::OFF_CONTROL, 0);
        bus(0, wdt_pkg::OFF_CONTROL, 0);
        `CHK(q[15:0], 16'h00a2)
        pulses(3);
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], 16'h0002)
        pulses(3);
        `CHK({irq, rreq}, 2'b10)
        resets(1);
        bus(1, wdt_pkg::OFF_LOAD, 5);
        bus(1, wdt_pkg::OFF_CONTROL, 16'h00a0);
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        pulses(6);
        `CHK({irq, rreq}, 2'b01)
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        `CHK(rreq, 1'b0)
        pulses(6);
        resets(0);
        `CHK(rreq, 1'b0)
        bus(1, wdt_pkg::OFF_LOAD, 9);
        bus(0, wdt_pkg::OFF_LOAD, 0);
        `CHK(q[15:0], 16'h0005)
        bus(1, wdt_pkg::OFF_CLEAR, 0);
        pulses(2);
        bus(0, wdt_pkg::OFF_VALUE, 0);
        `CHK(q[15:0], 16'h0003)
        wrap_up();
    end
endmodule : tb
